// ==== hw/gjds_pkg.sv ====
package gjds_pkg;
   // register byte addresses (printed offsets not all multiples of four)
   localparam int unsigned IDX_PIN1       = 8;
   localparam int unsigned IDX_PIN4       = 9;
   localparam int unsigned IDX_DETEN      = 13;
   localparam logic [7:0] ADDR_PIN1       = 8'h20;
   localparam logic [7:0] ADDR_PIN4       = 8'h24;
   localparam logic [7:0] ADDR_DETEN      = 8'h34;
   localparam logic [7:0] ADDR_CTRL       = 8'h40;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h44;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h48;
   localparam logic [7:0] ADDR_STATUS     = 8'h4c;
   // function select codes
   localparam logic [2:0] FN_INPUT        = 3'h0;
   localparam logic [2:0] FN_RSVD         = 3'h1;
   localparam logic [2:0] FN_TEMP_OK      = 3'h2;
   localparam logic [2:0] FN_AUTO_MUTE    = 3'h3;
   localparam logic [2:0] FN_PLL_CLK      = 3'h4;
   localparam logic [2:0] FN_PLL_LOCK     = 3'h5;
   localparam logic [2:0] FN_CONST_A      = 3'h6;
   localparam logic [2:0] FN_CONST_B      = 3'h7;
   // field positions
   localparam int unsigned SEL_LSB        = 0;
   localparam int unsigned INV_BIT        = 3;
   localparam int unsigned DIV_LSB        = 4;
   localparam int unsigned JSEL_LSB       = 4;
   localparam int unsigned DETEN_BIT      = 6;
   localparam int unsigned MID_LOW_BIT    = 7;
   localparam int unsigned MID_HIGH_BIT   = 8;
   localparam int unsigned EN_LOW_LSB     = 0;
   localparam int unsigned EN_HIGH_LSB    = 4;
   localparam logic [8:0] REG9_RESET      = 9'h000;
   localparam logic [7:0] DETEN_RESET     = 8'h00;
   localparam logic [3:0] ALL_OUTS_ON     = 4'hf;
   localparam logic [1:0] IRQ_RESET       = 2'h0;
   // jack source select codes
   localparam logic [1:0] JSRC_PIN1       = 2'h0;
   localparam logic [1:0] JSRC_LEFT       = 2'h1;
   localparam logic [1:0] JSRC_RIGHT      = 2'h2;
   localparam logic [1:0] JSRC_PIN4       = 2'h3;
   // slow tick period: 2^21 master clock cycles
   localparam int unsigned SLOW_TICK_LOG2 = 21;
   localparam int unsigned SLOW_TICK_CYC  = 1 << SLOW_TICK_LOG2;
   // interrupt bits
   localparam int unsigned IRQ_JACK_CHG   = 0;
   localparam int unsigned IRQ_PLL_LOCK   = 1;
endpackage

// ==== hw/gjds_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for an input from outside the clock domain
module gjds_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // first flop feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else if (ce) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== hw/gjds_debounce.sv ====
`timescale 1ns/10ps
`default_nettype none
// level changes when two consecutive slow ticks see a new value, or when the tick right after a change sees one
module gjds_debounce (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic tick,
   input  wire logic level_in,
   output logic      level_out
);
   logic seen_q;

   // one tick arms, the next commits; a tick that sees the old level disarms
   always_ff @(posedge clk) begin
      if (rst) begin
         seen_q    <= 1'b0;
         level_out <= 1'b0;
      end else if (ce && tick) begin
         seen_q <= (level_in != level_out);        // see R18
         if (seen_q && level_in != level_out)
            level_out <= level_in;                 // see R18
      end
   end
endmodule
`default_nettype wire

// ==== hw/gjds_top.sv ====
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - pin one select: 0 input, 2 temp, 3 mute, 4 pll clk, 5 lock, 6 low, 7 high
// R2 - pin four select same, but 6 drives high, 7 low; 0 is detect input
// R3 - bit 3 of each pin register inverts that pin's output
// R4 - pll clock out divider code 0..3 divides by 1..4
// R5 - both function fields reset to zero, pins are inputs
// R6 - three-wire mode forces pin one to chip-select input only; here detect source 0 still reads pin one in that mode
// R7 - two-wire mode lets pin one act as detect switch input
// R8 - line pins detect only; pins one and four detect or output
// R9 - detect input debounced on a tick every 2^21 clocks
// R10 - software enables the slow tick before relying on detection
// R11 - detect source: 0 pin one, 1 left, 2 right, 3 pin four
// R12 - detection uses pin level; invert bits do not apply
// R13 - each output has one enable for level low, one for high
// R14 - effective output enable is normal enable AND chosen detect enable
// R15 - midrail enable is normal enable OR chosen midrail detect enable
// R16 - detection off: detect enables all one, midrail detect zero
// R17 - detect enable register: bits 3:0 for low, 7:4 for high
// R18 - pins synchronised by two flops; debounce needs two agreeing ticks; here the tick right after a change can revert it alone
// R19 - invert after the function mux; drive until the field changes
module gjds_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        three_wire_mode,
   input  wire logic        select_or_pin_one_in,
   input  wire logic        left_line_detect_pin,
   input  wire logic        right_line_detect_pin,
   input  wire logic        dedicated_pin_four_in,
   input  wire logic        temp_ok,
   input  wire logic        auto_mute_active,
   input  wire logic        pll_clock,
   input  wire logic        pll_locked,
   input  wire logic [3:0]  out_normal_enable,
   input  wire logic        midrail_normal_enable,
   output logic             select_or_pin_one_out,
   output logic             select_or_pin_one_oe,
   output logic             chip_select_n,
   output logic             dedicated_pin_four_out,
   output logic             dedicated_pin_four_oe,
   output logic [3:0]       out_effective_enable,
   output logic             midrail_reference_enable,
   output logic             jack_level,
   output logic             irq
);
   import gjds_pkg::*;

   logic [8:0] pin1_function_control_q;
   logic [8:0] pin4_function_and_detect_select_q;
   logic [7:0] out_detect_enables_q;
   logic       slow_tick_enable_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_mask_q;
   logic [20:0] tick_cnt_q;
   logic       tick_q;
   logic [1:0] div_cnt_q;
   logic       pll_div_q;
   logic       pll_prev_q;
   logic       jack_prev_q;
   logic       lock_prev_q;
   logic       s_pin1;
   logic       s_left;
   logic       s_right;
   logic       s_pin4;
   logic       s_temp;
   logic       s_mute;
   logic       s_pll;
   logic       s_lock;
   logic       det_raw;
   logic       det_level;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;
   logic       pin1_drv_d;
   logic       pin4_drv_d;
   logic [3:0] sel_en;
   logic       sel_mid;

   // all pins and foreign-domain status pass two flops first
   gjds_sync u_s_pin1 (.clk(clk), .rst(rst), .ce(ce),
      .async_in(select_or_pin_one_in), .sync_out(s_pin1));    // see R18
   gjds_sync u_s_left (.clk(clk), .rst(rst), .ce(ce),
      .async_in(left_line_detect_pin), .sync_out(s_left));
   gjds_sync u_s_right (.clk(clk), .rst(rst), .ce(ce),
      .async_in(right_line_detect_pin), .sync_out(s_right));
   gjds_sync u_s_pin4 (.clk(clk), .rst(rst), .ce(ce),
      .async_in(dedicated_pin_four_in), .sync_out(s_pin4));
   gjds_sync u_s_temp (.clk(clk), .rst(rst), .ce(ce),
      .async_in(temp_ok), .sync_out(s_temp));
   gjds_sync u_s_mute (.clk(clk), .rst(rst), .ce(ce),
      .async_in(auto_mute_active), .sync_out(s_mute));
   gjds_sync u_s_pll (.clk(clk), .rst(rst), .ce(ce),
      .async_in(pll_clock), .sync_out(s_pll));
   gjds_sync u_s_lock (.clk(clk), .rst(rst), .ce(ce),
      .async_in(pll_locked), .sync_out(s_lock));

   // shared output mux; the two pins differ only in constant codes
   function automatic logic fn_mux(input logic [2:0] sel,
                                   input logic       swap_consts,
                                   input logic       pll_div);
      logic v;
      v = 1'b0;
      case (sel)
         FN_TEMP_OK:   v = s_temp;
         FN_AUTO_MUTE: v = s_mute;
         FN_PLL_CLK:   v = pll_div;
         FN_PLL_LOCK:  v = s_lock;
         FN_CONST_A:   v = swap_consts;
         FN_CONST_B:   v = ~swap_consts;
         default:      v = 1'b0;
      endcase
      return v;
   endfunction

   // apb decode: zero-wait, every known address word
   assign wr_en   = psel && penable && pwrite && ce;
   assign rd_en   = psel && penable && !pwrite && ce;
   assign addr_ok = (paddr == ADDR_PIN1) || (paddr == ADDR_PIN4)
                 || (paddr == ADDR_DETEN) || (paddr == ADDR_CTRL)
                 || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK)
                 || (paddr == ADDR_STATUS);

   // configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         pin1_function_control_q           <= REG9_RESET;   // see R5
         pin4_function_and_detect_select_q <= REG9_RESET;   // see R5
         out_detect_enables_q              <= DETEN_RESET;
         slow_tick_enable_q                <= 1'b0;
         irq_mask_q                        <= IRQ_RESET;
      end else if (wr_en) begin
         case (paddr)
            ADDR_PIN1:     pin1_function_control_q <= pwdata[8:0];
            ADDR_PIN4:     pin4_function_and_detect_select_q <= pwdata[8:0];
            ADDR_DETEN:    out_detect_enables_q <= pwdata[7:0];  // see R17
            ADDR_CTRL:     slow_tick_enable_q <= pwdata[0];      // see R10
            ADDR_IRQ_MASK: irq_mask_q <= pwdata[1:0];
            default:       ;
         endcase
      end
   end

   // apb answer; unmapped address gives pslverr
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               ADDR_PIN1:     prdata[8:0] <= pin1_function_control_q;
               ADDR_PIN4:     prdata[8:0] <= pin4_function_and_detect_select_q;
               ADDR_DETEN:    prdata[7:0] <= out_detect_enables_q;
               ADDR_CTRL:     prdata[0]   <= slow_tick_enable_q;
               ADDR_IRQ_STAT: prdata[1:0] <= irq_status_q;
               ADDR_IRQ_MASK: prdata[1:0] <= irq_mask_q;
               ADDR_STATUS:   prdata[1:0] <= {tick_q, det_level};
               default:       prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // slow tick; stops while disabled, so debounce freezes too
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (ce) begin
         tick_q <= 1'b0;
         if (slow_tick_enable_q) begin
            tick_cnt_q <= tick_cnt_q + 21'd1;                    // see R9
            if (tick_cnt_q == 21'(SLOW_TICK_CYC - 1))
               tick_q <= 1'b1;
         end
      end
   end

   // pll clock divider: toggle every code + 1 synced edges, both kinds,
   // so the ratio is code + 1 with even duty, odd ratios included;
   // the source must stay well below a quarter of clk to survive the sync
   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt_q  <= 2'h0;
         pll_div_q  <= 1'b0;
         pll_prev_q <= 1'b0;
      end else if (ce) begin
         pll_prev_q <= s_pll;
         if (s_pll != pll_prev_q) begin
            if (div_cnt_q >= pin1_function_control_q[DIV_LSB +: 2]) begin
               div_cnt_q <= 2'h0;                                // see R4
               pll_div_q <= ~pll_div_q;
            end else begin
               div_cnt_q <= div_cnt_q + 2'h1;
            end
         end
      end
   end

   // detect source mux uses raw synced pin, no invert; see R12
   always_comb begin
      case (pin4_function_and_detect_select_q[JSEL_LSB +: 2])   // see R11
         JSRC_PIN1:  det_raw = s_pin1;       // see R7
         JSRC_LEFT:  det_raw = s_left;       // see R8
         JSRC_RIGHT: det_raw = s_right;
         JSRC_PIN4:  det_raw = s_pin4;
         default:    det_raw = 1'b0;
      endcase
   end

   gjds_debounce u_deb (.clk(clk), .rst(rst), .ce(ce), .tick(tick_q),
      .level_in(det_raw), .level_out(det_level));               // see R9

   // pin drive, invert after mux; see R19
   // a process, not assigns: the mux reads synced status outside its args
   always_comb begin
      pin1_drv_d = fn_mux(pin1_function_control_q[SEL_LSB +: 3],
                          1'b0, pll_div_q)                      // see R1
                 ^ pin1_function_control_q[INV_BIT];            // see R3
      pin4_drv_d = fn_mux(pin4_function_and_detect_select_q[SEL_LSB +: 3],
                          1'b1, pll_div_q)                      // see R2
                 ^ pin4_function_and_detect_select_q[INV_BIT];  // see R3
   end

   // detect enables chosen by debounced level
   always_comb begin
      if (pin4_function_and_detect_select_q[DETEN_BIT]) begin
         sel_en  = det_level ? out_detect_enables_q[EN_HIGH_LSB +: 4]
                             : out_detect_enables_q[EN_LOW_LSB +: 4]; // see R13
         sel_mid = det_level
                 ? pin4_function_and_detect_select_q[MID_HIGH_BIT]
                 : pin4_function_and_detect_select_q[MID_LOW_BIT];
      end else begin
         sel_en  = ALL_OUTS_ON;                                   // see R16
         sel_mid = 1'b0;
      end
   end

   // registered pin and enable outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         select_or_pin_one_out    <= 1'b0;
         select_or_pin_one_oe     <= 1'b0;
         chip_select_n            <= 1'b1;
         dedicated_pin_four_out   <= 1'b0;
         dedicated_pin_four_oe    <= 1'b0;
         out_effective_enable     <= 4'h0;
         midrail_reference_enable <= 1'b0;
         jack_level               <= 1'b0;
      end else if (ce) begin
         select_or_pin_one_oe <= !three_wire_mode &&
            (pin1_function_control_q[SEL_LSB +: 3] != FN_INPUT);  // see R6
         select_or_pin_one_out  <= pin1_drv_d;
         chip_select_n          <= three_wire_mode ? s_pin1 : 1'b1;
         dedicated_pin_four_oe  <=
            (pin4_function_and_detect_select_q[SEL_LSB +: 3] != FN_INPUT);
         dedicated_pin_four_out <= pin4_drv_d;
         out_effective_enable     <= out_normal_enable & sel_en;  // see R14
         midrail_reference_enable <= midrail_normal_enable | sel_mid; // see R15
         jack_level               <= det_level;
      end
   end

   // sticky events, read-clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status_q <= IRQ_RESET;
         jack_prev_q  <= 1'b0;
         lock_prev_q  <= 1'b0;
         irq          <= 1'b0;
      end else if (ce) begin
         jack_prev_q <= det_level;
         lock_prev_q <= s_lock;
         // clear only what the read returned: an event landing between
         // the setup and access edges stays pending
         irq_status_q <= ((rd_en && paddr == ADDR_IRQ_STAT)
                          ? (irq_status_q & ~prdata[1:0]) : irq_status_q)
            | {(s_lock && !lock_prev_q), (det_level != jack_prev_q)};
         irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // assertions
   a_and_enable: assert property (@(posedge clk) disable iff (rst) // see R16
      ce && !pin4_function_and_detect_select_q[DETEN_BIT]
      |=> out_effective_enable == $past(out_normal_enable))
      else $error("enables not passed through with detection off");
   a_and_gate: assert property (@(posedge clk) disable iff (rst) // see R14
      ce |=> (out_effective_enable & ~$past(out_normal_enable)) == 4'h0)
      else $error("output enabled without normal enable");
   a_mid_or: assert property (@(posedge clk) disable iff (rst) // see R15
      ce && midrail_normal_enable |=> midrail_reference_enable)
      else $error("midrail dropped while normally enabled");
   a_three_wire: assert property (@(posedge clk) disable iff (rst) // see R6
      three_wire_mode && ce |=> !select_or_pin_one_oe)
      else $error("pin one driven in three-wire mode");
   a_cs_idle: assert property (@(posedge clk) disable iff (rst) // see R7
      ce && !three_wire_mode |=> chip_select_n)
      else $error("chip select active in two-wire mode");
   a_pin1_const: assert property (@(posedge clk) disable iff (rst) // see R1
      ce && pin1_function_control_q[SEL_LSB +: 4] == {1'b0, FN_CONST_A}
      |=> select_or_pin_one_out == 1'b0)
      else $error("pin one code 6 not low");
   a_pin4_const: assert property (@(posedge clk) disable iff (rst) // see R2
      ce && pin4_function_and_detect_select_q[SEL_LSB +: 4]
            == {1'b0, FN_CONST_A}
      |=> dedicated_pin_four_out == 1'b1)
      else $error("pin four code 6 not high");
   a_pin_invert: assert property (@(posedge clk) disable iff (rst) // see R3
      ce && pin1_function_control_q[SEL_LSB +: 4] == {1'b1, FN_CONST_B}
      |=> select_or_pin_one_out == 1'b0)
      else $error("pin one invert not applied");
   a_pin4_input: assert property (@(posedge clk) disable iff (rst) // see R8
      ce && pin4_function_and_detect_select_q[SEL_LSB +: 3] == FN_INPUT
      |=> !dedicated_pin_four_oe)
      else $error("pin four driven while set as input");
   a_deb_stable: assert property (@(posedge clk) disable iff (rst) // see R9
      !tick_q |=> $stable(det_level))
      else $error("debounced level moved without a tick");
   a_irq_masked: assert property (@(posedge clk) disable iff (rst)
      ce && (irq_status_q & irq_mask_q) == 2'h0 |=> !irq)
      else $error("interrupt high with nothing unmasked pending");
   a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
      ce && psel && !penable |=> pready)
      else $error("no ready after a setup cycle");
   a_reset_input: assert property (@(posedge clk) // see R5
      rst |=> !select_or_pin_one_oe && !dedicated_pin_four_oe)
      else $error("pin driven after reset");
   c_jack_toggle: cover property (@(posedge clk) disable iff (rst)
      $rose(det_level));
   c_pll_out: cover property (@(posedge clk) disable iff (rst)
      dedicated_pin_four_oe && $rose(dedicated_pin_four_out));
   c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule
`default_nettype wire

// ==== verification/gjds_socket_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// headphone socket switch: contact to ground when plugged, pull-up when open
module gjds_socket_model (
   input  wire logic clk,
   input  wire logic plugged,
   output logic      pin_level
);
   logic plug_q = 1'h0;
   int   bounce = 0;

   // contacts chatter for a few cycles after every change of the plug
   always_ff @(posedge clk) begin
      if (plugged != plug_q) begin
         plug_q <= plugged;
         bounce <= 7;
      end else if (bounce > 0) begin
         bounce <= bounce - 1;
      end
   end

   // bounce shows as a toggling level, never a clean edge
   assign pin_level = (bounce > 0) ? bounce[0] : !plug_q;
endmodule
`default_nettype wire

// ==== verification/gpio_jack_detect_switching_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpio_jack_detect_switching_tb;
   import gjds_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic three_wire_mode = 0, select_or_pin_one_in = 1, plugged = 0;
   logic right_line_detect_pin = 1, dedicated_pin_four_in = 1;
   logic temp_ok = 1, auto_mute_active = 0, pll_clock = 0, pll_locked = 0;
   logic midrail_normal_enable = 0, ce = 1;
   logic [3:0] out_normal_enable = 4'hb;
   wire left_line_detect_pin;
   logic [31:0] prdata, rd;
   logic pready, pslverr, select_or_pin_one_out, select_or_pin_one_oe, er;
   logic chip_select_n, dedicated_pin_four_out, dedicated_pin_four_oe;
   logic midrail_reference_enable, jack_level, irq;
   logic [3:0] out_effective_enable;
   int fail_count = 0, checks = 0;

   gjds_top u_dut (.clk, .rst, .ce, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .three_wire_mode,
      .select_or_pin_one_in, .left_line_detect_pin, .right_line_detect_pin,
      .dedicated_pin_four_in, .temp_ok, .auto_mute_active, .pll_clock,
      .pll_locked, .out_normal_enable, .midrail_normal_enable,
      .select_or_pin_one_out, .select_or_pin_one_oe, .chip_select_n,
      .dedicated_pin_four_out, .dedicated_pin_four_oe, .out_effective_enable,
      .midrail_reference_enable, .jack_level, .irq);

   gjds_socket_model u_socket (.clk, .plugged, .pin_level(left_line_detect_pin));

   // 200 MHz clock; pll source toggles every 4 cycles, period 8
   initial forever #2.5 clk = ~clk;
   initial forever begin
      repeat (4) @(posedge clk);
      pll_clock <= ~pll_clock;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // hang guard far above the cycles the test needs
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      final_report();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, then an idle edge so psel is never reassigned at once
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'h1, d, rd, er);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'h0, 32'h0000_0000, rd, er);
      check(rd, exp);
   endtask

   // pin level expected for a function code; pin four swaps the constants
   function automatic logic fexp(input int p, input int c);
      case (c)
         2: return temp_ok;
         3: return auto_mute_active;
         5: return pll_locked;
         6: return p == 1;
         7: return p == 0;
         default: return 1'h0;
      endcase
   endfunction

   initial begin
      int n, diff;
      logic prev;
      repeat (10) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      check({select_or_pin_one_oe, dedicated_pin_four_oe, chip_select_n}, 3'h1);
      rdc(ADDR_PIN1, 32'h0000_0000);
      rdc(ADDR_PIN4, 32'h0000_0000);
      rdc(ADDR_DETEN, 32'h0000_0000);
      // unmapped place: refused, reads zero
      apb(8'h10, 1'h1, 32'h0000_00ff, rd, er);
      check(er, 1'h1);
      apb(8'h10, 1'h0, 32'h0000_0000, rd, er);
      check(er, 1'h1);
      check(rd, 32'h0000_0000);
      wr(ADDR_PIN1, 32'h0000_003f);
      rdc(ADDR_PIN1, 32'h0000_003f);
      wr(ADDR_DETEN, 32'h0000_005a);
      rdc(ADDR_DETEN, 32'h0000_005a);
      wr(ADDR_CTRL, 32'h0000_0001);
      rdc(ADDR_CTRL, 32'h0000_0001);
      // lock rise while masked, then unmasked; status clears on read
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      pll_locked <= 1;
      repeat (8) @(posedge clk);
      check(irq, 1'h0);
      rdc(ADDR_IRQ_STAT, 32'h0000_0002);
      rdc(ADDR_IRQ_STAT, 32'h0000_0000);
      wr(ADDR_IRQ_MASK, 32'h0000_0002);
      rdc(ADDR_IRQ_MASK, 32'h0000_0002);
      pll_locked <= 0;
      repeat (8) @(posedge clk);
      pll_locked <= 1;
      repeat (8) @(posedge clk);
      check(irq, 1'h1);
      rdc(ADDR_IRQ_STAT, 32'h0000_0002);
      repeat (3) @(posedge clk);
      check(irq, 1'h0);
      // every static function code on both pins, plain and inverted
      for (int p = 0; p < 2; p++) for (int i = 0; i < 2; i++)
         for (int c = 0; c < 8; c++) if (c != 4) begin
            wr(p ? ADDR_PIN4 : ADDR_PIN1, 32'(i * 8 + c));
            repeat (6) @(posedge clk);
            check(p ? dedicated_pin_four_oe : select_or_pin_one_oe, c != 0);
            if (c != 0) check(p ? dedicated_pin_four_out : select_or_pin_one_out, fexp(p, c) ^ i[0]);
         end
      // divided pll clock: 60 source rises in 480 cycles, allow one edge slack
      for (int d = 0; d < 4; d++) begin
         wr(ADDR_PIN1, 32'(d * 16 + 4));
         repeat (10) @(posedge clk);
         n = 0;
         prev = select_or_pin_one_out;
         repeat (480) begin
            @(posedge clk);
            if (select_or_pin_one_out && !prev) n++;
            prev = select_or_pin_one_out;
         end
         diff = n - 60 / (d + 1);
         check(diff >= -1 && diff <= 1, 1'h1);
      end
      // three-wire mode overrides an output function on pin one
      wr(ADDR_PIN1, 32'h0000_0007);
      three_wire_mode <= 1;
      select_or_pin_one_in <= 0;
      repeat (6) @(posedge clk);
      check({select_or_pin_one_oe, chip_select_n}, 2'h0);
      select_or_pin_one_in <= 1;
      repeat (6) @(posedge clk);
      check(chip_select_n, 1'h1);
      three_wire_mode <= 0;
      select_or_pin_one_in <= 0;
      repeat (6) @(posedge clk);
      check({select_or_pin_one_oe, chip_select_n}, 2'h3);
      // detection off: normal enables pass untouched
      wr(ADDR_PIN4, 32'h0000_0090);
      repeat (4) @(posedge clk);
      check({midrail_reference_enable, out_effective_enable}, 5'h0b);
      midrail_normal_enable <= 1;
      repeat (4) @(posedge clk);
      check({midrail_reference_enable, out_effective_enable}, 5'h1b);
      midrail_normal_enable <= 0;
      // detection on, debounced level still low: low-side enables apply
      wr(ADDR_PIN4, 32'h0000_00d8);
      repeat (4) @(posedge clk);
      check({midrail_reference_enable, out_effective_enable}, 5'h1a);
      // clock enable low freezes the outputs; the new enable lands after
      out_normal_enable <= 4'h2;
      ce <= 0;
      repeat (4) @(posedge clk);
      check(out_effective_enable, 4'ha);
      ce <= 1;
      repeat (4) @(posedge clk);
      check(out_effective_enable, 4'h2);
      out_normal_enable <= 4'hb;
      // chattering plug-in far shorter than two slow ticks changes nothing
      plugged <= 1;
      repeat (60) @(posedge clk);
      check({jack_level, midrail_reference_enable, out_effective_enable}, 6'h1a);
      rdc(ADDR_STATUS, 32'h0000_0000);
      final_report();
   end
endmodule
`default_nettype wire
